// ---- include/pmd_params.svh ----
// constants of the peripheral module disable block
`ifndef PMD_PARAMS_SVH
`define PMD_PARAMS_SVH

`define PMD_NUM_REGS      5
`define PMD_NUM_CH        40
`define PMD_OFS_CTRL0     12'h000
`define PMD_OFS_CTRL1     12'h004
`define PMD_OFS_CTRL2     12'h008
`define PMD_OFS_CTRL3     12'h00C
`define PMD_OFS_CTRL4     12'h010
`define PMD_OFS_STAT0     12'h020
`define PMD_STAT_GRP_BIT  5
`define PMD_MASK_CTRL0    8'hC7
`define PMD_MASK_CTRL1    8'hFF
`define PMD_MASK_CTRL2    8'h66
`define PMD_MASK_CTRL3    8'hFF
`define PMD_MASK_CTRL4    8'h22
`define PMD_RESET_CTRL    8'h00
`define PMD_CHAN_MASK     40'h22FF66FF47
`define PMD_SYSTEM_CLOCK_NET_USERS  40'h22FF00FF07
`define PMD_BIT_SYSTEM_CLOCK_NET    7
`define PMD_BIT_VREF      6
`define PMD_BIT_NVM       2
`define PMD_BIT_REFCLK    1
`define PMD_BIT_PINCHG    0
`define PMD_CLK_NS        20
`define PMD_INSTR_CLKS    4
`define PMD_NVM_WAKE_NS   1000
`define PMD_NVM_WAKE_CYC  ((`PMD_NVM_WAKE_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)

`endif

// ---- include/pmd_pkg.sv ----
// types shared by the peripheral module disable block
package pmd_pkg;
	typedef enum logic [2:0] {
		PMD_ST_ON   = 3'b001,
		PMD_ST_OFF  = 3'b010,
		PMD_ST_WAKE = 3'b100
	} pmd_state_e;
	typedef logic [7:0] pmd_byte_t;
endpackage

// ---- logic/pmd_chan.sv ----
// per-peripheral disable sequencer with registered gates
`timescale 1ns/1ps
`default_nettype none
module pmd_chan #(
	parameter int WAKE_CYCLES = 4
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic off,
	input  wire logic sys_gate,
	output var  logic clk_en,
	output var  logic rst_n,
	output var  logic out_en,
	output var  logic insel_en,
	output var  logic active
);
	localparam int CW = (WAKE_CYCLES > 1) ? $clog2(WAKE_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(WAKE_CYCLES - 1);

	if (WAKE_CYCLES < 1) begin : g_bad
		$error("pmd_chan: WAKE_CYCLES must be at least one");
	end

	pmd_pkg::pmd_state_e state_r;
	pmd_pkg::pmd_state_e state_nxt;
	logic [CW-1:0]       cnt_r;
	logic [CW-1:0]       cnt_nxt;
	logic                wake_done;

	assign wake_done = (cnt_r == LAST);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		unique case (state_r)
			pmd_pkg::PMD_ST_ON: begin
				if (off)
					state_nxt = pmd_pkg::PMD_ST_OFF;
			end
			pmd_pkg::PMD_ST_OFF: begin
				cnt_nxt = '0;
				if (!off)
					state_nxt = pmd_pkg::PMD_ST_WAKE;
			end
			pmd_pkg::PMD_ST_WAKE: begin
				cnt_nxt = cnt_r + CW'(1);
				if (off)
					state_nxt = pmd_pkg::PMD_ST_OFF;
				else if (wake_done)
					state_nxt = pmd_pkg::PMD_ST_ON;
			end
			default: state_nxt = pmd_pkg::PMD_ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r  <= pmd_pkg::PMD_ST_ON;
			cnt_r    <= '0;
			clk_en   <= 1'b1;
			rst_n    <= 1'b1;
			out_en   <= 1'b1;
			insel_en <= 1'b1;
			active   <= 1'b1;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			clk_en   <= (state_nxt != pmd_pkg::PMD_ST_OFF) && !sys_gate;
			rst_n    <= (state_nxt == pmd_pkg::PMD_ST_ON);
			out_en   <= (state_nxt == pmd_pkg::PMD_ST_ON);
			insel_en <= (state_nxt == pmd_pkg::PMD_ST_ON);
			active   <= (state_nxt == pmd_pkg::PMD_ST_ON);
		end
	end
endmodule // pmd_chan
`default_nettype wire

// ---- logic/pmd_sfr_guard.sv ----
// blanks register access of peripherals that are not active
`timescale 1ns/1ps
`default_nettype none
module pmd_sfr_guard #(
	parameter int N = 40
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic [N-1:0] active,
	input  wire logic [N-1:0] sfr_sel,
	input  wire logic         sfr_wr,
	input  wire logic         sfr_rd,
	input  wire logic [N*8-1:0] sfr_rdata_in,
	output var  logic [N-1:0] sfr_wr_go,
	output var  logic [7:0]   sfr_rdata
);
	if (N < 1) begin : g_bad
		$error("pmd_sfr_guard: N must be at least one");
	end

	logic [N*8-1:0] lane;
	logic [7:0]     rd_or;

	for (genvar i = 0; i < N; i++) begin : g_lane
		assign lane[i*8 +: 8] = (sfr_sel[i] && active[i]) ?
			sfr_rdata_in[i*8 +: 8] : 8'h00;
	end

	always_comb begin
		rd_or = 8'h00;
		for (int i = 0; i < N; i++)
			rd_or = rd_or | lane[i*8 +: 8];
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sfr_wr_go <= '0;
			sfr_rdata <= 8'h00;
		end else begin
			sfr_wr_go <= sfr_wr ? (sfr_sel & active) : '0;
			sfr_rdata <= sfr_rd ? rd_or : 8'h00;
		end
	end
endmodule // pmd_sfr_guard
`default_nettype wire

// ---- logic/pmd_top.sv ----
// peripheral module disable controller with APB register port
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"
module pmd_top #(
	parameter int          ADDR_W        = 12,
	parameter int          WAKE_CYCLES   = `PMD_INSTR_CLKS,
	parameter int          NVM_WAKE      = `PMD_NVM_WAKE_CYC,
	parameter logic [39:0] SYSTEM_CLOCK_NET_USERS  = `PMD_SYSTEM_CLOCK_NET_USERS
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// peripheral gates, one lane per control bit
	output var  logic              system_clock_net_net_en,
	output var  logic [39:0]       periph_clk_en,
	output var  logic [39:0]       periph_rst_n,
	output var  logic [39:0]       periph_out_en,
	output var  logic [39:0]       periph_insel_en,
	// peripheral register access path
	input  wire logic [39:0]       sfr_sel,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [319:0]      sfr_rdata_in,
	output var  logic [39:0]       sfr_wr_go,
	output var  logic [7:0]        sfr_rdata,
	// nonvolatile memory access path
	input  wire logic              ee_rd_req,
	input  wire logic              ee_wr_req,
	input  wire logic              nonvol_control_regs_wr_req,
	input  wire logic [7:0]        ind_ee_rdata_in,
	output var  logic              ee_rd_go,
	output var  logic              ee_wr_go,
	output var  logic              nonvol_control_regs_wr_go,
	output var  logic [7:0]        ind_ee_rdata,
	output var  logic              nvm_data_ready
);
	localparam int NCH = `PMD_NUM_CH;
	localparam int NR  = `PMD_NUM_REGS;
	localparam int NVM_CH = `PMD_BIT_NVM;
	localparam int NCW = (NVM_WAKE > 1) ? $clog2(NVM_WAKE + 1) : 1;
	localparam logic [NCW-1:0] NVM_DONE = NCW'(NVM_WAKE);
	localparam logic [NCH-1:0] CHAN_MASK = `PMD_CHAN_MASK;
	localparam logic [8*NR-1:0] REG_MASK = {
		`PMD_MASK_CTRL4, `PMD_MASK_CTRL3, `PMD_MASK_CTRL2,
		`PMD_MASK_CTRL1, `PMD_MASK_CTRL0
	};
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = ADDR_W'(`PMD_OFS_CTRL0);
	localparam logic [ADDR_W-1:0] OFS_CTRL4 = ADDR_W'(`PMD_OFS_CTRL4);
	localparam logic [ADDR_W-1:0] OFS_STAT0 = ADDR_W'(`PMD_OFS_STAT0);
	localparam logic [ADDR_W-1:0] OFS_STAT4 =
		ADDR_W'(`PMD_OFS_STAT0 + `PMD_OFS_CTRL4);

	if (ADDR_W < 6) begin : g_bad_addr
		$error("pmd_top: ADDR_W must be at least 6");
	end
	if (WAKE_CYCLES < 1) begin : g_bad_wake
		$error("pmd_top: WAKE_CYCLES must be at least one");
	end
	if (NVM_WAKE < 1) begin : g_bad_nvm
		$error("pmd_top: NVM_WAKE must be at least one");
	end

	// control registers, flattened lane by lane
	pmd_pkg::pmd_byte_t ctrl_r [NR];
	logic [8*NR-1:0]    ctrl_flat;
	logic [NCH-1:0]     chan_active;
	logic [8*NR-1:0]    stat_flat;

	for (genvar r = 0; r < NR; r++) begin : g_flat
		assign ctrl_flat[r*8 +: 8] = ctrl_r[r];
	end

	// named control fields
	logic periph_system_clock_net_off;
	logic voltage_ref_off;
	logic nonvol_mem_off;
	logic ref_clock_out_off;
	logic pin_change_irq_off;
	logic num_ctrl_osc_off;
	logic async_serial_off;
	logic sync_serial_port_off;
	logic timer_six_off;
	logic timer_five_off;
	logic timer_four_off;
	logic timer_three_off;
	logic timer_two_off;
	logic timer_one_off;
	logic timer_zero_off;
	logic dig_to_analog_off;
	logic analog_to_dig_off;
	logic comparator_two_off;
	logic comparator_one_off;
	logic waveform_gen_two_off;
	logic waveform_gen_one_off;
	logic pwm_six_off;
	logic pwm_five_off;
	logic capcomp_four_off;
	logic capcomp_three_off;
	logic capcomp_two_off;
	logic capcomp_one_off;

	assign periph_system_clock_net_off    = ctrl_r[0][`PMD_BIT_SYSTEM_CLOCK_NET];
	assign voltage_ref_off      = ctrl_r[0][`PMD_BIT_VREF];
	assign nonvol_mem_off       = ctrl_r[0][`PMD_BIT_NVM];
	assign ref_clock_out_off    = ctrl_r[0][`PMD_BIT_REFCLK];
	assign pin_change_irq_off   = ctrl_r[0][`PMD_BIT_PINCHG];
	assign num_ctrl_osc_off     = ctrl_r[1][7];
	assign async_serial_off     = ctrl_r[4][5];
	assign sync_serial_port_off = ctrl_r[4][1];
	assign timer_six_off        = ctrl_r[1][6];
	assign timer_five_off       = ctrl_r[1][5];
	assign timer_four_off       = ctrl_r[1][4];
	assign timer_three_off      = ctrl_r[1][3];
	assign timer_two_off        = ctrl_r[1][2];
	assign timer_one_off        = ctrl_r[1][1];
	assign timer_zero_off       = ctrl_r[1][0];
	assign dig_to_analog_off    = ctrl_r[2][6];
	assign analog_to_dig_off    = ctrl_r[2][5];
	assign comparator_two_off   = ctrl_r[2][2];
	assign comparator_one_off   = ctrl_r[2][1];
	assign waveform_gen_two_off = ctrl_r[3][7];
	assign waveform_gen_one_off = ctrl_r[3][6];
	assign pwm_six_off          = ctrl_r[3][5];
	assign pwm_five_off         = ctrl_r[3][4];
	assign capcomp_four_off     = ctrl_r[3][3];
	assign capcomp_three_off    = ctrl_r[3][2];
	assign capcomp_two_off      = ctrl_r[3][1];
	assign capcomp_one_off      = ctrl_r[3][0];

	// lane 8r+b follows register r bit b; the network bit is no lane
	logic [NCH-1:0] off_vec;
	assign off_vec = {
		2'b00, async_serial_off, 3'b000, sync_serial_port_off, 1'b0,
		waveform_gen_two_off, waveform_gen_one_off, pwm_six_off,
		pwm_five_off, capcomp_four_off, capcomp_three_off,
		capcomp_two_off, capcomp_one_off,
		1'b0, dig_to_analog_off, analog_to_dig_off, 2'b00,
		comparator_two_off, comparator_one_off, 1'b0,
		num_ctrl_osc_off, timer_six_off, timer_five_off, timer_four_off,
		timer_three_off, timer_two_off, timer_one_off, timer_zero_off,
		1'b0, voltage_ref_off, 3'b000, nonvol_mem_off,
		ref_clock_out_off, pin_change_irq_off
	};

	// bus decode
	logic                 setup_ph;
	logic                 access_ph;
	logic                 in_ctrl;
	logic                 in_stat;
	logic                 aligned;
	logic                 hit;
	logic [2:0]           reg_idx;
	logic                 wr_fire;
	logic [7:0]           rd_byte;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable && pready;
	assign aligned   = (paddr[1:0] == 2'b00);
	assign in_ctrl   = aligned && (paddr >= OFS_CTRL0) && (paddr <= OFS_CTRL4);
	assign in_stat   = aligned && (paddr >= OFS_STAT0) && (paddr <= OFS_STAT4);
	assign hit       = in_ctrl || in_stat;
	assign reg_idx   = paddr[4:2];
	assign wr_fire   = access_ph && pwrite && in_ctrl && pstrb[0];
	assign rd_byte   = in_ctrl ? ctrl_flat[reg_idx*8 +: 8] :
		in_stat ? stat_flat[reg_idx*8 +: 8] : 8'h00;

	// bus response, no wait states
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !hit;
			prdata  <= (setup_ph && !pwrite) ? {24'h00_0000, rd_byte} :
				32'h0000_0000;
		end
	end

	for (genvar r = 0; r < NR; r++) begin : g_reg
		always_ff @(posedge clk_sys) begin
			if (!reset_n) begin
				ctrl_r[r] <= `PMD_RESET_CTRL;
			end else if (wr_fire && reg_idx == 3'(r)) begin
				ctrl_r[r] <= pwdata[7:0] & REG_MASK[r*8 +: 8];
			end
		end
	end

	// system clock network gate
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			system_clock_net_net_en <= 1'b1;
		else
			system_clock_net_net_en <= !periph_system_clock_net_off;
	end

	// one sequencer per implemented disable bit except the network bit
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		if (CHAN_MASK[i]) begin : g_on
			logic sys_gate;
			assign sys_gate = SYSTEM_CLOCK_NET_USERS[i] && periph_system_clock_net_off;
			pmd_chan #(
				.WAKE_CYCLES (WAKE_CYCLES)
			) u_chan (
				.clk_sys  (clk_sys),
				.reset_n  (reset_n),
				.off      (off_vec[i]),
				.sys_gate (sys_gate),
				.clk_en   (periph_clk_en[i]),
				.rst_n    (periph_rst_n[i]),
				.out_en   (periph_out_en[i]),
				.insel_en (periph_insel_en[i]),
				.active   (chan_active[i])
			);
		end else begin : g_none
			assign periph_clk_en[i]   = 1'b0;
			assign periph_rst_n[i]    = 1'b0;
			assign periph_out_en[i]   = 1'b0;
			assign periph_insel_en[i] = 1'b0;
			assign chan_active[i]     = 1'b0;
		end
	end

	// status view: which peripherals run
	assign stat_flat = chan_active;

	pmd_sfr_guard #(
		.N (NCH)
	) u_guard (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.active       (chan_active),
		.sfr_sel      (sfr_sel),
		.sfr_wr       (sfr_wr),
		.sfr_rd       (sfr_rd),
		.sfr_rdata_in (sfr_rdata_in),
		.sfr_wr_go    (sfr_wr_go),
		.sfr_rdata    (sfr_rdata)
	);

	// memory wake timer
	logic [NCW-1:0] nvm_cnt_r;
	logic [NCW-1:0] nvm_cnt_nxt;
	logic           nvm_ok;
	logic           nvm_gate;

	assign nvm_cnt_nxt = !chan_active[NVM_CH] ? '0 :
		(nvm_cnt_r == NVM_DONE) ? nvm_cnt_r : nvm_cnt_r + NCW'(1);
	assign nvm_ok = chan_active[NVM_CH] && (nvm_cnt_r == NVM_DONE);
	// gate ee reads, writes and pointer data on the registered flag; control register writes need only the lane active
	assign nvm_gate = nvm_data_ready && chan_active[NVM_CH];

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			nvm_cnt_r      <= '0;
			nvm_data_ready <= 1'b0;
			ee_rd_go       <= 1'b0;
			ee_wr_go       <= 1'b0;
			nonvol_control_regs_wr_go   <= 1'b0;
			ind_ee_rdata   <= 8'h00;
		end else begin
			nvm_cnt_r      <= nvm_cnt_nxt;
			nvm_data_ready <= nvm_ok;
			ee_rd_go       <= ee_rd_req && nvm_gate;
			ee_wr_go       <= ee_wr_req && nvm_gate;
			nonvol_control_regs_wr_go   <= nonvol_control_regs_wr_req && chan_active[NVM_CH];
			ind_ee_rdata   <= nvm_gate ? ind_ee_rdata_in : 8'h00;
		end
	end
endmodule // pmd_top
`default_nettype wire

// ---- verif/pmd_top_props.sv ----
// assertions on the peripheral module disable ports
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"
module pmd_top_props #(
	parameter logic [39:0] SYSTEM_CLOCK_NET_USERS = 40'h0
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        system_clock_net_net_en,
	input wire logic [39:0] periph_clk_en,
	input wire logic [39:0] periph_rst_n,
	input wire logic [39:0] periph_out_en,
	input wire logic [39:0] periph_insel_en,
	input wire logic [39:0] sfr_sel,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [39:0] sfr_wr_go,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        ee_rd_req,
	input wire logic        nonvol_control_regs_wr_req,
	input wire logic        ee_rd_go,
	input wire logic        nonvol_control_regs_wr_go,
	input wire logic [7:0]  ind_ee_rdata,
	input wire logic        nvm_data_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	chk_reset_lanes: assert property (disable iff (1'b0)
		!reset_n |=> periph_rst_n == `PMD_CHAN_MASK && system_clock_net_net_en)
		else $error("lanes not on after reset");
	chk_lane_unused: assert property (
		((periph_clk_en | periph_rst_n | periph_out_en) & ~`PMD_CHAN_MASK)
		== 40'h0) else $error("unused lane active");
	chk_out_gated: assert property (
		(periph_out_en & ~periph_rst_n) == 40'h0)
		else $error("output enabled while in reset");
	chk_insel_follow: assert property (
		periph_insel_en == periph_out_en) else $error("input select live");
	chk_system_clock_net_gate: assert property (
		!system_clock_net_net_en && !$past(system_clock_net_net_en) |->
		(periph_clk_en & SYSTEM_CLOCK_NET_USERS) == 40'h0)
		else $error("clock runs with network off");
	chk_wake_clock: assert property (
		$rose(periph_rst_n[8]) |-> $past(periph_clk_en[8]))
		else $error("reset released without clock");
	chk_blank_write: assert property (
		sfr_wr && (sfr_sel & periph_rst_n) == 40'h0 |=> sfr_wr_go == 40'h0)
		else $error("write reached disabled lane");
	chk_blank_read: assert property (
		sfr_rd && (sfr_sel & periph_rst_n) == 40'h0 |=> sfr_rdata == 8'h00)
		else $error("read of disabled lane not zero");
	chk_nvm_block: assert property (
		ee_rd_req && !nvm_data_ready |=> !ee_rd_go)
		else $error("memory read while blocked");
	chk_nvm_ptr: assert property (
		!nvm_data_ready |=> ind_ee_rdata == 8'h00)
		else $error("pointer read not zero");
	chk_nvm_ctl: assert property (
		nonvol_control_regs_wr_req && !periph_rst_n[2] |=> !nonvol_control_regs_wr_go)
		else $error("memory control written while off");
	chk_apb_ready: assert property (
		psel && !penable |=> pready) else $error("no access phase answer");
endmodule // pmd_top_props
bind pmd_top pmd_top_props #(.SYSTEM_CLOCK_NET_USERS(SYSTEM_CLOCK_NET_USERS)) props_i (
	.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pready(pready), .system_clock_net_net_en(system_clock_net_net_en),
	.periph_clk_en(periph_clk_en), .periph_rst_n(periph_rst_n),
	.periph_out_en(periph_out_en), .periph_insel_en(periph_insel_en),
	.sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wr_go(sfr_wr_go), .sfr_rdata(sfr_rdata), .ee_rd_req(ee_rd_req),
	.nonvol_control_regs_wr_req(nonvol_control_regs_wr_req), .ee_rd_go(ee_rd_go),
	.nonvol_control_regs_wr_go(nonvol_control_regs_wr_go), .ind_ee_rdata(ind_ee_rdata),
	.nvm_data_ready(nvm_data_ready));
`default_nettype wire

// ---- verif/pmd_periph_model.sv ----
// register file model of the gated peripherals
`timescale 1ns/1ps
`default_nettype none
module pmd_periph_model (
	input  wire logic         clk_sys,
	input  wire logic [39:0]  periph_rst_n,
	input  wire logic [39:0]  sfr_wr_go,
	input  wire logic [7:0]   wdat,
	output var  logic [319:0] sfr_rdata_in
);
	localparam logic [7:0] POR_VAL = 8'h5A;
	logic [7:0] reg_r [40];
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 40; i++) begin
			if (!periph_rst_n[i])
				reg_r[i] <= POR_VAL;
			else if (sfr_wr_go[i])
				reg_r[i] <= wdat;
		end
	end
	always_comb begin
		for (int i = 0; i < 40; i++)
			sfr_rdata_in[8*i +: 8] = reg_r[i];
	end
endmodule // pmd_periph_model
`default_nettype wire

// ---- verif/tb_pmd_top.sv ----
// self-checking bench of the peripheral module disable block
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"
module tb_pmd_top;
	localparam int WK = 2;
	typedef struct packed {logic [2:0] r; logic [7:0] wd, mk;} pmd_row_s;
	logic         clk_sys = 0, reset_n = 0, psel = 0, penable = 0;
	logic         pwrite = 0, sfr_wr = 0, sfr_rd = 0, e;
	logic [11:0]  paddr = 0;
	logic [31:0]  pwdata = 0, prdata;
	logic         pready, pslverr, system_clock_net_net_en, ee_rd_go, ee_wr_go;
	logic         nonvol_control_regs_wr_go, nvm_data_ready;
	logic [2:0]   req = 0;
	logic [39:0]  clk_en, rst_n, out_en, insel_en, sel = 0, wr_go;
	logic [7:0]   wdat = 0, rdat, ind_out, q;
	logic [319:0] rd_in;
	int           error_cnt = 0, compares = 0, cyc = 0, n;
	pmd_row_s     rows [10] = '{'{0, 8'hFF, 8'hC7}, '{0, 8'h00, 8'hC7},
		'{1, 8'hA5, 8'hFF}, '{1, 8'h00, 8'hFF}, '{2, 8'hFF, 8'h66},
		'{2, 8'h00, 8'h66}, '{3, 8'h5A, 8'hFF}, '{3, 8'h00, 8'hFF},
		'{4, 8'hFF, 8'h22}, '{4, 8'h00, 8'h22}};
	pmd_top #(.WAKE_CYCLES(WK), .NVM_WAKE(3)) pmd_top_i (
		.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.system_clock_net_net_en(system_clock_net_net_en), .periph_clk_en(clk_en),
		.periph_rst_n(rst_n), .periph_out_en(out_en),
		.periph_insel_en(insel_en), .sfr_sel(sel), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata_in(rd_in), .sfr_wr_go(wr_go),
		.sfr_rdata(rdat), .ee_rd_req(req[2]), .ee_wr_req(req[1]),
		.nonvol_control_regs_wr_req(req[0]), .ind_ee_rdata_in(8'hA5),
		.ee_rd_go(ee_rd_go), .ee_wr_go(ee_wr_go),
		.nonvol_control_regs_wr_go(nonvol_control_regs_wr_go), .ind_ee_rdata(ind_out),
		.nvm_data_ready(nvm_data_ready));
	pmd_periph_model pmd_periph_model_i (.clk_sys(clk_sys),
		.periph_rst_n(rst_n), .sfr_wr_go(wr_go), .wdat(wdat),
		.sfr_rdata_in(rd_in));
	task cmp(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_sys);
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		psel <= 1;
		@(posedge clk_sys);
		penable <= 1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one strobe on the register path or the memory path
	task strobe(input int ln, input logic w, input logic [2:0] rq);
		@(posedge clk_sys);
		sel <= 40'h1 << ln;
		sfr_wr <= w && ln >= 0;
		sfr_rd <= !w && ln >= 0;
		wdat <= 8'h3C ^ {7'h0, w};
		req <= rq;
		@(posedge clk_sys);
		sfr_wr <= 0;
		sfr_rd <= 0;
		req <= 0;
		// results stand between this edge and the next
		@(negedge clk_sys);
	endtask
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1;
		cmp(rst_n, `PMD_CHAN_MASK);
		for (int r = 0; r < 5; r++) begin
			apb(12'(r * 4), 0, 0);
			cmp(q, 0);
		end
		foreach (rows[i]) begin
			apb(12'({rows[i].r, 2'b00}), 1, rows[i].wd);
			repeat (WK + 4) @(posedge clk_sys);
			apb(12'({rows[i].r, 2'b00}), 0, 0);
			cmp(q, rows[i].wd & rows[i].mk);
			cmp(rst_n[rows[i].r*8 +: 8],
				8'(`PMD_CHAN_MASK >> rows[i].r*8) & ~rows[i].wd);
			cmp(out_en[rows[i].r*8 +: 8],
				8'(`PMD_CHAN_MASK >> rows[i].r*8) & ~rows[i].wd);
			if (rows[i].r == 0)
				cmp(system_clock_net_net_en, !rows[i].wd[7]);
		end
		apb(12'h014, 0, 0);
		cmp({e, q}, 9'h100);
		strobe(8, 1, 0);
		cmp(wr_go, 40'h100);
		strobe(8, 0, 0);
		cmp(rdat, 8'h3D);
		apb(12'h004, 1, 8'h01);
		repeat (2) @(posedge clk_sys);
		cmp({clk_en[8], rst_n[8], insel_en[8]}, 0);
		strobe(8, 1, 0);
		cmp(wr_go, 0);
		strobe(8, 0, 0);
		cmp(rdat, 0);
		apb(12'h024, 0, 0);
		cmp(q, 8'hFE);
		apb(12'h004, 1, 0);
		for (n = 0; rst_n[8] !== 1'b1 && n < 20; n++)
			@(posedge clk_sys);
		cmp(n <= WK + 4, 1);
		strobe(8, 0, 0);
		cmp(rdat, 8'h5A);
		apb(12'h000, 1, 8'h80);
		repeat (2) @(posedge clk_sys);
		cmp({system_clock_net_net_en, clk_en[8], rst_n[8], clk_en[21]}, 4'h3);
		apb(12'h000, 1, 0);
		strobe(-1, 0, 3'b111);
		cmp({ee_rd_go, ee_wr_go, nonvol_control_regs_wr_go, ind_out}, 11'h7A5);
		apb(12'h000, 1, 8'h04);
		repeat (2) @(posedge clk_sys);
		strobe(-1, 0, 3'b111);
		cmp({ee_rd_go, ee_wr_go, nonvol_control_regs_wr_go, ind_out}, 0);
		apb(12'h000, 1, 0);
		repeat (WK + 2) @(posedge clk_sys);
		cmp(nvm_data_ready, 0);
		repeat (8) @(posedge clk_sys);
		cmp(nvm_data_ready, 1);
		apb(12'h00C, 1, 8'hFF);
		repeat (2) @(posedge clk_sys);
		cmp(rst_n[31:24], 0);
		reset_n <= 0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1;
		apb(12'h00C, 0, 0);
		cmp({q, rst_n}, {8'h00, `PMD_CHAN_MASK});
		complete_run();
	end
endmodule // tb_pmd_top
`default_nettype wire
